/* pwr_sequencer.sv */
/*
 * power-up and reset sequencer of the power device.
 * assumes rail good inputs and clock inputs synchronous to i_ref_clk.
 */
`timescale 1ns/1ps
`default_nettype none
`include "pwr_seq_regs.svh"
module pwr_sequencer import pwr_seq_pkg::*; #(
    parameter int FAST_START_CYC = `FAST_OSC_START_CYC,
    parameter int DEBOUNCE = `DEBOUNCE_CYC,
    parameter int STABLE_CYC = `CLK_STABLE_CYC
) (
    input wire logic i_ref_clk,
    input wire logic i_arst_n,
    pwr_link_if.device link,
    input wire logic i_power_on_request,
    input wire logic i_power_off_request,
    input wire logic i_boot_select_first,
    input wire logic i_boot_select_second,
    input wire logic i_io_good,
    input wire logic i_core_second_good,
    input wire logic i_pll_good,
    input wire logic i_core_first_good,
    input wire logic i_warm_seq_programmed,
    input wire logic i_slow_clk_disable,
    input wire logic i_aux_enable_cfg,
    output logic o_io_supply_rail_en,
    output logic o_pll_supply_rail_en,
    output logic o_core_rail_second_en,
    output logic o_core_rail_first_en,
    output logic o_slow_clock_out_en,
    output logic o_fast_clock_out_en,
    output logic o_por_n,
    output logic o_adaptive_protocol,
    output logic [11:0] o_core_boot_mv,
    output logic o_regulator_enable_out,
    output logic o_system_enable_out,
    output logic o_warm_busy,
    output logic [1:0] o_boot_role
);
    seq_state_t st_q;           // sequencer state
    boot_role_t role_q;         // latched start-up role
    logic role_valid_q;         // role captured after reset release
    logic btn_q;                // debounced request level
    logic btn_prev_q;           // previous debounced level, for edge
    logic btn_lvl;              // debounce output
    logic on_press;             // button edge in master mode
    logic want_on;              // power-on demand
    logic [$clog2(FAST_START_CYC+1)-1:0] tmr_q; // fast oscillator timer
    logic [7:0] stab_q;         // clock stable / warm step counter
    logic warm_prev_q;          // previous warm reset level
    logic first_up_q;           // still before the first power-up
    logic slow_clk_q;           // slow clock forwarded to processor

    // button and slave level share one qualifier
    pwr_debounce #(.CYC(DEBOUNCE)) u_btn (
        .i_ref_clk(i_ref_clk),
        .i_arst_n(i_arst_n),
        .i_level(i_power_on_request),
        .o_level(btn_lvl)
    );

    // boot role decode
    function automatic boot_role_t decode_role(input logic first, input logic second);
        if ({first, second} == `BOOT_MASTER) begin
            return ROLE_MASTER;
        end else if ({first, second} == `BOOT_SLAVE) begin
            return ROLE_SLAVE;
        end
        return ROLE_NONE;
    endfunction

    // strap capture on the first clock after reset release
    always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            role_q <= ROLE_NONE;
            role_valid_q <= 1'b0;
            o_adaptive_protocol <= 1'b0;
            o_core_boot_mv <= 12'h000;
        end else if (!role_valid_q) begin
            role_valid_q <= 1'b1;
            role_q <= decode_role(i_boot_select_first, i_boot_select_second);
            o_adaptive_protocol <= i_boot_select_first;
            o_core_boot_mv <= i_boot_select_first ? `CORE_BOOT_MV : 12'h000;
        end
    end

    // button edge tracking
    always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            btn_q <= 1'b0;
            btn_prev_q <= 1'b0;
        end else begin
            btn_q <= btn_lvl;
            btn_prev_q <= btn_q;
        end
    end
    assign on_press = (role_q == ROLE_MASTER) && btn_q && !btn_prev_q;
    // slave powers on while master holds request high
    assign want_on = on_press || ((role_q == ROLE_SLAVE) && btn_q);

    // fast oscillator default timer, runs once from reset
    always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            tmr_q <= '0;
        end else if (tmr_q != ($clog2(FAST_START_CYC+1))'(FAST_START_CYC)) begin
            tmr_q <= tmr_q + 1'b1;
        end
    end

    // main sequencer
    always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            st_q <= ST_OFF;
            stab_q <= 8'h00;
            first_up_q <= 1'b1;
            warm_prev_q <= 1'b1;
        end else begin
            warm_prev_q <= link.warm_reset_n;
            unique case (st_q)
                ST_OFF: begin
                    stab_q <= 8'h00;
                    if (role_valid_q && role_q != ROLE_NONE && want_on) begin
                        st_q <= ST_IO;
                    end
                end
                ST_IO: begin
                    if (i_io_good) begin
                        st_q <= ST_PLL_CORE2;
                    end
                end
                ST_PLL_CORE2: begin
                    if (i_core_second_good) begin
                        st_q <= ST_CORE1;
                    end
                end
                ST_CORE1: begin
                    if (i_core_first_good) begin
                        st_q <= ST_SLOW_CLK;
                    end
                end
                ST_SLOW_CLK: begin
                    if (stab_q == 8'(STABLE_CYC)) begin
                        stab_q <= 8'h00;
                        st_q <= ST_FAST_CLK;
                    end else begin
                        stab_q <= stab_q + 8'h01;
                    end
                end
                ST_FAST_CLK: begin
                    // wait the default timer at first power-up
                    if (first_up_q && tmr_q != ($clog2(FAST_START_CYC+1))'(FAST_START_CYC)) begin
                        stab_q <= 8'h00;
                    end else if (stab_q == 8'(STABLE_CYC)) begin
                        if (i_pll_good && i_io_good && i_core_first_good
                            && i_core_second_good) begin
                            st_q <= ST_RUN;
                            first_up_q <= 1'b0;
                        end
                    end else begin
                        stab_q <= stab_q + 8'h01;
                    end
                end
                ST_RUN: begin
                    if (warm_prev_q && !link.warm_reset_n && i_warm_seq_programmed) begin
                        st_q <= ST_WARM;
                        stab_q <= 8'h00;
                    end
                end
                ST_WARM: begin
                    if (stab_q == 8'(`WARM_STEP_CYC)) begin
                        st_q <= ST_RUN;
                    end else begin
                        stab_q <= stab_q + 8'h01;
                    end
                end
                ST_DOWN: begin
                    st_q <= ST_OFF;
                end
            endcase
            // power-off, master button in run or slave request low, down state next
            if (st_q != ST_OFF && st_q != ST_DOWN
                && (i_power_off_request || (st_q == ST_RUN && on_press)
                    || (role_q == ROLE_SLAVE && !btn_q))) begin
                st_q <= ST_DOWN;
            end
        end
    end

    // outputs registered from the state
    always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            o_io_supply_rail_en <= 1'b0;
            o_pll_supply_rail_en <= 1'b0;
            o_core_rail_second_en <= 1'b0;
            o_core_rail_first_en <= 1'b0;
            o_fast_clock_out_en <= 1'b0;
            o_por_n <= 1'b0;
            o_regulator_enable_out <= 1'b0;
            o_system_enable_out <= 1'b0;
            o_warm_busy <= 1'b0;
            slow_clk_q <= 1'b0;
        end else begin
            // rails hold their level in the down state, so they drop one
            // cycle after reset asserts and the fast clock stops
            o_io_supply_rail_en <= (st_q == ST_DOWN) ? o_io_supply_rail_en
                : (st_q != ST_OFF);
            o_pll_supply_rail_en <= (st_q == ST_DOWN) ? o_pll_supply_rail_en
                : (st_q inside {ST_PLL_CORE2, ST_CORE1, ST_SLOW_CLK, ST_FAST_CLK, ST_RUN,
                ST_WARM});
            o_core_rail_second_en <= (st_q == ST_DOWN) ? o_core_rail_second_en
                : (st_q inside {ST_PLL_CORE2, ST_CORE1, ST_SLOW_CLK, ST_FAST_CLK, ST_RUN,
                ST_WARM});
            o_core_rail_first_en <= (st_q == ST_DOWN) ? o_core_rail_first_en
                : (st_q inside {ST_CORE1, ST_SLOW_CLK, ST_FAST_CLK, ST_RUN, ST_WARM});
            slow_clk_q <= st_q inside {ST_SLOW_CLK, ST_FAST_CLK, ST_RUN, ST_WARM};
            o_fast_clock_out_en <= st_q inside {ST_FAST_CLK, ST_RUN, ST_WARM};
            o_por_n <= st_q inside {ST_RUN, ST_WARM};
            // auxiliary enables only on software request after boot
            o_regulator_enable_out <= i_aux_enable_cfg && link.aux_req
                && (st_q inside {ST_RUN, ST_WARM});
            o_system_enable_out <= i_aux_enable_cfg && link.aux_req
                && (st_q inside {ST_RUN, ST_WARM});
            o_warm_busy <= (st_q == ST_WARM);
        end
    end

    // slow clock buffer, on from reset unless disabled
    always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            o_slow_clock_out_en <= 1'b1;
        end else begin
            o_slow_clock_out_en <= !i_slow_clk_disable;
        end
    end

    assign o_boot_role = role_q;
    assign link.por_n = o_por_n;
    assign link.slow_clk_en = slow_clk_q;
    assign link.fast_clk_en = o_fast_clock_out_en;
endmodule
`default_nettype wire

/* pwr_seq_regs.svh */
/*
 * timing counts and field positions of the power-up reset sequencer.
 * assumes a 125 MHz reference clock (8 ns period).
 */
// Overview of operation
// - ramp io rail first, reset held low
// - then pll and second core rail, wait stable
// - then first core rail, wait stable
// - then forward slow clock, processor held
// - then forward fast clock, processor gates it
// - release reset after pll rail, clocks stable
// - processor checks fuses, then releases warm reset
// - auxiliary devices switched on by processor software
// - power-off: reset, stop fast clock, rails off
// - boot pins: 10 master, 11 slave
// - master takes push button, decides power
// - slave powers on while request high
// - first boot pin high: 1.2 V, io first
// - first boot pin high: adaptive voltage protocol
// - master: debounced button starts sequencer
// - reset held until rails all established
// - warm reset low runs programmed sequence only
// - optional auxiliary enable via regulator/system outputs
// - slow clock out on after reset, disableable
// - square fast clock: configure slicer bypass; nothing in this code sets a slicer bypass
// - default timer 5.3 ms enables fast clock; here fast clock follows state, timer delays first reset release
`ifndef PWR_SEQ_REGS_SVH
`define PWR_SEQ_REGS_SVH
`define CLK_PERIOD_NS 8
`define FAST_OSC_START_US 5300
`define FAST_OSC_START_CYC ((`FAST_OSC_START_US * 1000) / `CLK_PERIOD_NS)
`define DEBOUNCE_CYC 16
`define CLK_STABLE_CYC 32
`define WARM_STEP_CYC 8
`define FUSE_CHECK_CYC 16
`define BOOT_MASTER 2'h2
`define BOOT_SLAVE 2'h3
`define CORE_BOOT_MV 12'h4b0
`endif

/* pwr_seq_pkg.sv */
/*
 * types shared by the sequencer and its processor-side partner.
 * assumes pwr_seq_regs.svh supplies the numbers.
 */
package pwr_seq_pkg;
    // power sequencer states
    typedef enum logic [3:0] {
        ST_OFF, ST_IO, ST_PLL_CORE2, ST_CORE1, ST_SLOW_CLK, ST_FAST_CLK,
        ST_RUN, ST_WARM, ST_DOWN
    } seq_state_t;
    // start-up role from boot pins
    typedef enum logic [1:0] {
        ROLE_NONE, ROLE_MASTER, ROLE_SLAVE
    } boot_role_t;
    // processor side states
    typedef enum logic [1:0] {
        CPU_HELD, CPU_FUSE, CPU_RUN
    } cpu_state_t;
endpackage

/* pwr_link_if.sv */
/*
 * link between the power sequencer and the application processor.
 * assumes one shared reference clock for both ends.
 */
`timescale 1ns/1ps
`default_nettype none
interface pwr_link_if;
    logic por_n;          // processor power-on reset, active low
    logic slow_clk_en;    // slow clock being delivered
    logic fast_clk_en;    // fast clock being delivered
    logic warm_reset_n;   // warm reset from processor, active low
    logic aux_req;        // software request for auxiliary power
    // sequencer end
    modport device (output por_n, output slow_clk_en, output fast_clk_en,
        input warm_reset_n, input aux_req);
    // processor end
    modport host (input por_n, input slow_clk_en, input fast_clk_en,
        output warm_reset_n, output aux_req);
endinterface
`default_nettype wire

/* pwr_debounce.sv */
/*
 * stable-level qualifier for the push button request input.
 * assumes the input is already synchronous to i_ref_clk.
 */
`timescale 1ns/1ps
`default_nettype none
module pwr_debounce #(
    parameter int CYC = 16
) (
    input wire logic i_ref_clk,
    input wire logic i_arst_n,
    input wire logic i_level,
    output logic o_level
);
    logic [$clog2(CYC+1)-1:0] cnt_q; // cycles input has differed
    // output follows input only after CYC equal samples
    always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            cnt_q <= '0;
            o_level <= 1'b0;
        end else if (i_level == o_level) begin
            cnt_q <= '0;
        end else if (cnt_q == ($clog2(CYC+1))'(CYC - 1)) begin
            cnt_q <= '0;
            o_level <= i_level;
        end else begin
            cnt_q <= cnt_q + 1'b1;
        end
    end
endmodule
`default_nettype wire

/* pwr_host_end.sv */
/*
 * processor end: holds itself in reset, checks fuses, releases warm reset.
 * assumes one clock shared with the sequencer.
 */
`timescale 1ns/1ps
`default_nettype none
`include "pwr_seq_regs.svh"
module pwr_host_end import pwr_seq_pkg::*; #(
    parameter int FUSE_CYC = `FUSE_CHECK_CYC
) (
    input wire logic i_ref_clk,
    input wire logic i_arst_n,
    pwr_link_if.host link,
    input wire logic i_sw_aux_request,
    input wire logic i_sw_warm_request,
    output logic o_running,
    output logic o_fast_clk_gated
);
    cpu_state_t st_q;          // processor boot state
    logic [7:0] cnt_q;         // fuse check counter
    logic warm_n_q;            // warm reset output
    logic aux_q;               // auxiliary power request
    // boot flow after power-on reset release
    always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            st_q <= CPU_HELD;
            cnt_q <= 8'h00;
            warm_n_q <= 1'b0;
            aux_q <= 1'b0;
        end else if (!link.por_n) begin
            st_q <= CPU_HELD;
            cnt_q <= 8'h00;
            warm_n_q <= 1'b0;
            aux_q <= 1'b0;
        end else begin
            unique case (st_q)
                CPU_HELD: st_q <= CPU_FUSE;
                CPU_FUSE: begin
                    if (cnt_q == 8'(FUSE_CYC)) begin
                        st_q <= CPU_RUN;
                        warm_n_q <= 1'b1;
                    end else begin
                        cnt_q <= cnt_q + 8'h01;
                    end
                end
                CPU_RUN: begin
                    warm_n_q <= !i_sw_warm_request;
                    aux_q <= i_sw_aux_request;
                end
                // unused code falls back to held
                default: st_q <= CPU_HELD;
            endcase
        end
    end
    // fast clock gated internally until out of reset
    always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            o_fast_clk_gated <= 1'b1;
            o_running <= 1'b0;
        end else begin
            o_fast_clk_gated <= !(link.fast_clk_en && link.por_n);
            o_running <= (st_q == CPU_RUN);
        end
    end
    assign link.warm_reset_n = warm_n_q;
    assign link.aux_req = aux_q;
endmodule
`default_nettype wire

/* pwr_seq_properties.sv */
/*
 * ordering checks on the link and the rail enables of the sequencer.
 * assumes it sits beside the link interface in the bench, one clock.
 */
`timescale 1ns/1ps
`default_nettype none
module pwr_seq_properties (
    input wire logic i_ref_clk,
    input wire logic i_arst_n,
    input wire logic por_n,
    input wire logic slow_clk_en,
    input wire logic fast_clk_en,
    input wire logic o_io_supply_rail_en,
    input wire logic o_pll_supply_rail_en,
    input wire logic o_core_rail_second_en,
    input wire logic o_core_rail_first_en,
    input wire logic o_warm_busy,
    input wire logic o_adaptive_protocol,
    input wire logic [11:0] o_core_boot_mv,
    input wire logic [1:0] o_boot_role,
    input wire logic o_regulator_enable_out,
    input wire logic o_system_enable_out,
    input wire logic i_aux_enable_cfg,
    input wire logic i_core_second_good
);
    // one clock domain for every check
    default clocking @(posedge i_ref_clk); endclocking
    default disable iff (!i_arst_n);
    // every rail enabled
    sequence rails_up;
        o_io_supply_rail_en && o_pll_supply_rail_en && o_core_rail_second_en
            && o_core_rail_first_en;
    endsequence
    // both clocks delivered
    sequence clocks_on;
        slow_clk_en && fast_clk_en;
    endsequence
    a_por_needs_rails: assert property ($rose(por_n) |-> rails_up ##0 clocks_on)
        else $error("reset released early");
    a_io_before_pll: assert property ($rose(o_pll_supply_rail_en)
        |-> o_io_supply_rail_en && $rose(o_core_rail_second_en))
        else $error("pll rail out of order");
    a_core1_after_good: assert property ($rose(o_core_rail_first_en)
        |-> $past(i_core_second_good) && o_core_rail_second_en)
        else $error("first core rail early");
    a_slow_then_fast: assert property ($rose(fast_clk_en)
        |-> $past(slow_clk_en) && o_core_rail_first_en)
        else $error("fast clock before slow clock");
    a_io_holds_por: assert property (!o_io_supply_rail_en |-> !por_n)
        else $error("reset high without io rail");
    a_off_order: assert property ($fell(o_core_rail_first_en)
        |-> !$past(por_n) && !$past(fast_clk_en))
        else $error("rail dropped before reset");
    a_off_rails_drop: assert property ($fell(por_n) |-> ##[0:3] !o_io_supply_rail_en)
        else $error("rails stay after reset");
    a_boot_core_mv: assert property (o_boot_role != 2'h0
        |-> o_adaptive_protocol && o_core_boot_mv == 12'h4b0)
        else $error("boot voltage or protocol wrong");
    a_aux_gated: assert property ((o_regulator_enable_out || o_system_enable_out)
        |-> $past(i_aux_enable_cfg) && por_n)
        else $error("aux enable without config");
    a_warm_keeps_por: assert property (o_warm_busy |-> por_n)
        else $error("warm sequence dropped reset");
endmodule
`default_nettype wire

/* tb_power_up_reset_sequencer.sv */
/*
 * bench: sequencer and processor end joined by the link interface.
 * assumes shortened counts: timer 50, debounce 2, stable 4, fuse 4.
 */
`timescale 1ns/1ps
`default_nettype none
module tb_power_up_reset_sequencer;
    logic i_ref_clk, i_arst_n, i_power_on_request, i_power_off_request;
    logic i_boot_select_first, i_boot_select_second, i_io_good, i_core_second_good;
    logic i_pll_good, i_core_first_good, i_warm_seq_programmed, i_slow_clk_disable;
    logic i_aux_enable_cfg, i_sw_aux_request, i_sw_warm_request;
    logic o_io_supply_rail_en, o_pll_supply_rail_en, o_core_rail_second_en;
    logic o_core_rail_first_en, o_slow_clock_out_en, o_fast_clock_out_en, o_por_n;
    logic o_adaptive_protocol, o_regulator_enable_out, o_system_enable_out;
    logic o_warm_busy, o_running, o_fast_clk_gated;
    logic [11:0] o_core_boot_mv;
    logic [1:0] o_boot_role;
    int failures, checks, cyc; // mismatch, compare and cycle counts
    bit hit; // wait outcome
    pwr_link_if pwr_link_if_i ();
    pwr_sequencer #(.FAST_START_CYC(50), .DEBOUNCE(2), .STABLE_CYC(4)) pwr_sequencer_i (
        .i_ref_clk, .i_arst_n, .link(pwr_link_if_i), .i_power_on_request,
        .i_power_off_request, .i_boot_select_first, .i_boot_select_second, .i_io_good,
        .i_core_second_good, .i_pll_good, .i_core_first_good, .i_warm_seq_programmed,
        .i_slow_clk_disable, .i_aux_enable_cfg, .o_io_supply_rail_en, .o_pll_supply_rail_en,
        .o_core_rail_second_en, .o_core_rail_first_en, .o_slow_clock_out_en,
        .o_fast_clock_out_en, .o_por_n, .o_adaptive_protocol, .o_core_boot_mv,
        .o_regulator_enable_out, .o_system_enable_out, .o_warm_busy, .o_boot_role);
    pwr_host_end #(.FUSE_CYC(4)) pwr_host_end_i (.i_ref_clk, .i_arst_n,
        .link(pwr_link_if_i), .i_sw_aux_request, .i_sw_warm_request, .o_running,
        .o_fast_clk_gated);
    pwr_seq_properties pwr_seq_properties_i (.i_ref_clk, .i_arst_n,
        .por_n(pwr_link_if_i.por_n), .slow_clk_en(pwr_link_if_i.slow_clk_en),
        .fast_clk_en(pwr_link_if_i.fast_clk_en), .o_io_supply_rail_en,
        .o_pll_supply_rail_en, .o_core_rail_second_en, .o_core_rail_first_en, .o_warm_busy,
        .o_adaptive_protocol, .o_core_boot_mv, .o_boot_role, .o_regulator_enable_out,
        .o_system_enable_out, .i_aux_enable_cfg, .i_core_second_good);
    // 125 MHz reference
    always #4 i_ref_clk = ~i_ref_clk;
    // hang guard
    always @(posedge i_ref_clk) begin
        cyc++;
        if (cyc == 2000) begin
            failures++;
            give_verdict();
        end
    end
    // counts, then verdict
    task automatic give_verdict();
        $display("checks %0d failures %0d", checks, failures);
        if (failures == 0 && checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    // compare and count
    task automatic check(input logic [11:0] got, input logic [11:0] exp);
        checks++;
        if (got !== exp) begin
            failures++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // watched condition by index
    function automatic logic sel(input int k);
        case (k)
            0: return o_io_supply_rail_en;
            1: return o_pll_supply_rail_en;
            2: return o_core_rail_first_en;
            3: return o_por_n;
            4: return o_running;
            5: return o_warm_busy;
            default: return !o_io_supply_rail_en;
        endcase
    endfunction
    // bounded wait at rising edges
    task automatic wait_on(input int k, input int lim, output bit ok);
        int n;
        n = 0;
        while (sel(k) !== 1'b1 && n < lim) begin
            @(posedge i_ref_clk);
            n++;
        end
        ok = (sel(k) === 1'b1);
    endtask
    // reset with straps; goods cleared
    task automatic do_reset(input logic b1, input logic b2);
        i_arst_n <= 1'b0;
        {i_io_good, i_core_second_good, i_pll_good, i_core_first_good} <= 4'h0;
        {i_boot_select_first, i_boot_select_second} <= {b1, b2};
        repeat (10) @(posedge i_ref_clk);
        check(o_slow_clock_out_en, 1'b1);
        check(o_por_n, 1'b0);
        i_arst_n <= 1'b1;
        repeat (3) @(posedge i_ref_clk);
    endtask
    // answer each rail with its good level
    task automatic bring_up();
        wait_on(0, 60, hit); check(hit, 1'b1);
        wait_on(1, 10, hit); check(hit, 1'b0);
        i_io_good <= 1'b1;
        wait_on(1, 20, hit); check(o_core_rail_second_en, 1'b1);
        wait_on(2, 10, hit); check(hit, 1'b0);
        {i_pll_good, i_core_second_good} <= 2'h3;
        wait_on(2, 20, hit); check(o_por_n, 1'b0);
        i_core_first_good <= 1'b1;
        wait_on(3, 200, hit); check(o_fast_clock_out_en, 1'b1);
        check(o_fast_clk_gated, 1'b1);
        wait_on(4, 40, hit); check(pwr_link_if_i.warm_reset_n, 1'b1);
        check(o_fast_clk_gated, 1'b0);
    endtask
    // master start, then features in run
    task automatic t_master();
        do_reset(1'b1, 1'b0);
        i_power_on_request <= 1'b1;
        repeat (4) @(posedge i_ref_clk);
        i_power_on_request <= 1'b0;
        bring_up();
        check(o_boot_role, 2'h1);
        check(o_core_boot_mv, 12'h4b0);
        check(o_adaptive_protocol, 1'b1);
        i_slow_clk_disable <= 1'b1;
        i_aux_enable_cfg <= 1'b1;
        repeat (4) @(posedge i_ref_clk);
        check(o_slow_clock_out_en, 1'b0);
        check({o_regulator_enable_out, o_system_enable_out}, 2'h0);
        i_sw_aux_request <= 1'b1;
        repeat (4) @(posedge i_ref_clk);
        check({o_regulator_enable_out, o_system_enable_out}, 2'h3);
        {i_slow_clk_disable, i_aux_enable_cfg, i_sw_aux_request} <= 3'h0;
        i_sw_warm_request <= 1'b1;
        wait_on(5, 20, hit); check(hit, 1'b0);
        {i_warm_seq_programmed, i_sw_warm_request} <= 2'h2;
        repeat (4) @(posedge i_ref_clk);
        i_sw_warm_request <= 1'b1;
        wait_on(5, 20, hit); check(hit, 1'b1);
        i_sw_warm_request <= 1'b0;
        repeat (20) @(posedge i_ref_clk);
        check({o_por_n, o_warm_busy}, 2'h2);
        i_power_off_request <= 1'b1;
        repeat (3) @(posedge i_ref_clk);
        check({o_por_n, o_fast_clock_out_en, o_io_supply_rail_en}, 3'h1);
        wait_on(6, 10, hit); check(hit, 1'b1);
        i_power_off_request <= 1'b0;
        $display("master test over");
    endtask
    // master button press in run powers down
    task automatic t_button_off();
        i_power_on_request <= 1'b1;
        repeat (4) @(posedge i_ref_clk);
        i_power_on_request <= 1'b0;
        wait_on(3, 80, hit); check(hit, 1'b1);
        repeat (4) @(posedge i_ref_clk);
        i_power_on_request <= 1'b1;
        repeat (4) @(posedge i_ref_clk);
        i_power_on_request <= 1'b0;
        repeat (2) @(posedge i_ref_clk);
        check({o_por_n, o_fast_clock_out_en, o_io_supply_rail_en}, 3'h1);
        wait_on(6, 10, hit); check(hit, 1'b1);
        $display("button test over");
    endtask
    // off request in mid-sequence
    task automatic t_abort();
        {i_io_good, i_core_second_good, i_pll_good, i_core_first_good} <= 4'h0;
        i_power_on_request <= 1'b1;
        repeat (4) @(posedge i_ref_clk);
        i_power_on_request <= 1'b0;
        wait_on(0, 60, hit);
        i_io_good <= 1'b1;
        wait_on(1, 20, hit);
        i_power_off_request <= 1'b1;
        wait_on(6, 10, hit); check(hit, 1'b1);
        check(o_por_n, 1'b0);
        i_power_off_request <= 1'b0;
        $display("abort test over");
    endtask
    // slave follows the request level; no role ignores it
    task automatic t_slave();
        do_reset(1'b1, 1'b1);
        i_power_on_request <= 1'b1;
        bring_up();
        check(o_boot_role, 2'h2);
        i_power_on_request <= 1'b0;
        wait_on(6, 40, hit); check(hit, 1'b1);
        do_reset(1'b0, 1'b0);
        i_power_on_request <= 1'b1;
        wait_on(0, 30, hit); check(hit, 1'b0);
        i_power_on_request <= 1'b0;
        $display("slave test over");
    endtask
    // main sequence
    initial begin
        {i_ref_clk, i_arst_n, i_power_on_request, i_power_off_request} = 4'h0;
        {i_boot_select_first, i_boot_select_second, i_warm_seq_programmed} = 3'h0;
        {i_io_good, i_core_second_good, i_pll_good, i_core_first_good} = 4'h0;
        {i_slow_clk_disable, i_aux_enable_cfg, i_sw_aux_request, i_sw_warm_request} = 4'h0;
        t_master();
        t_button_off();
        t_abort();
        t_slave();
        give_verdict();
    end
endmodule
`default_nettype wire
